// ### ulmc_pkg.sv
// shared constants, types and helpers of the line and modem control block
package ulmc_pkg;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] ADDR_DIV_LO = 32'h5000_1000;
  localparam logic [31:0] ADDR_DIV_HI = 32'h5000_1004;
  localparam logic [31:0] ADDR_LINE_CTL = 32'h5000_100C;
  localparam logic [31:0] ADDR_MODEM_CTL = 32'h5000_1010;

  // ----------------------------------------------------------------
  // line_control fields
  // ----------------------------------------------------------------
  localparam int LC_LEN_LSB = 0;
  localparam int LC_STOP = 2;
  localparam int LC_PARITY_ON = 3;
  localparam int LC_EVEN = 4;
  localparam int LC_BREAK = 6;
  localparam int LC_DIV_ACCESS = 7;
  localparam logic [15:0] LINE_CTL_MASK = 16'h00DF;
  localparam logic [15:0] RST_LINE_CTL = 16'h0000;

  // ----------------------------------------------------------------
  // modem_control fields
  // ----------------------------------------------------------------
  localparam int MC_RTS = 1;
  localparam int MC_LOOP = 4;
  localparam int MC_AUTO = 5;
  localparam int MC_IR = 6;
  localparam logic [15:0] MODEM_CTL_MASK = 16'h0072;
  localparam logic [15:0] RST_MODEM_CTL = 16'h0000;

  // ----------------------------------------------------------------
  // divisor and frame timing, counted in half-bit ticks
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_DIVISOR = 16'h0000;
  localparam logic [2:0] BIT_HALVES = 3'h2;
  localparam logic [2:0] STOP_HALVES_ONE = 3'h2;
  localparam logic [2:0] STOP_HALVES_ONE_HALF = 3'h3;
  localparam logic [2:0] STOP_HALVES_TWO = 3'h4;
  localparam logic [3:0] MIN_DATA_BITS = 4'h5;

  // ----------------------------------------------------------------
  // frame state machines
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    FR_IDLE = 5'h01,
    FR_START = 5'h02,
    FR_DATA = 5'h04,
    FR_PAR = 5'h08,
    FR_STOP = 5'h10
  } ulmc_frame_e;

  // data bits per character from the length field
  function automatic logic [3:0] ulmc_data_bits(input logic [1:0] len);
    return MIN_DATA_BITS + {2'h0, len};
  endfunction

  // parity bit for the enabled data bits
  function automatic logic ulmc_parity(input logic [7:0] dat, input logic [1:0] len,
                                       input logic even);
    logic [7:0] m;
    m = 8'hFF >> (2'h3 - len);
    return even ? ^(dat & m) : ~^(dat & m);
  endfunction

endpackage

// ### ulmc_tick.sv
// half-bit tick generator driven by the divisor latch
`timescale 1ns/10ps
`default_nettype none

module ulmc_tick #(
  parameter int DIV_W = 16
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  // divisor
  input wire logic [DIV_W-1:0] divisor,
  // ticks
  output logic half_tick,
  output logic phase
);

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic tick;
    logic phase;
  } ulmc_tick_s;

  ulmc_tick_s q, d;

  // count divisor cycles per half bit, zero stops the ticks
  always_comb begin
    d = q;
    d.tick = 1'b0;
    if (divisor == '0) begin
      d.cnt = '0;
    end else if (q.cnt >= divisor - 1'b1) begin
      d.cnt = '0;
      d.tick = 1'b1;
    end else begin
      d.cnt = q.cnt + 1'b1;
    end
    if (q.tick) begin
      d.phase = ~q.phase;
    end
  end

  // state register
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign half_tick = q.tick;
  assign phase = q.phase;

endmodule

`default_nettype wire

// ### ulmc_tx.sv
// character serialiser: start, data, optional parity, stop bits
`timescale 1ns/10ps
`default_nettype none

module ulmc_tx (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  // timing and format
  input wire logic half_tick,
  input wire logic [1:0] len,
  input wire logic two_stop,
  input wire logic parity_on,
  input wire logic even,
  // character in
  input wire logic start,
  input wire logic [7:0] data,
  input wire logic cts_ok,
  // serial side
  output logic line,
  output logic first_half,
  output logic busy
);

  typedef struct packed {
    ulmc_pkg::ulmc_frame_e st;
    logic pend;
    logic [7:0] shift;
    logic [3:0] bitn;
    logic [2:0] halves;
    logic par;
    logic line;
    logic fh;
    logic busy;
  } ulmc_tx_s;

  ulmc_tx_s q, d;
  logic [2:0] stop_halves;
  logic [3:0] nbits;

  // frame sequencer, one step per half-bit tick
  always_comb begin
    d = q;
    nbits = ulmc_pkg::ulmc_data_bits(len);
    stop_halves = ulmc_pkg::STOP_HALVES_ONE;
    if (two_stop) begin
      stop_halves = (len == 2'h0) ? ulmc_pkg::STOP_HALVES_ONE_HALF
                                  : ulmc_pkg::STOP_HALVES_TWO;
    end
    // accept a character only when idle and nothing is waiting
    if (q.st == ulmc_pkg::FR_IDLE && start && !q.pend) begin
      d.pend = 1'b1;
      d.shift = data;
      d.par = ulmc_pkg::ulmc_parity(data, len, even);
    end
    if (half_tick) begin
      d.halves = q.halves + 3'h1;
      case (q.st)
        ulmc_pkg::FR_IDLE: begin
          d.halves = 3'h0;
          if (q.pend && cts_ok) begin
            d.st = ulmc_pkg::FR_START;
            d.pend = 1'b0;
            d.line = 1'b0;
          end
        end
        ulmc_pkg::FR_START: begin
          if (q.halves == ulmc_pkg::BIT_HALVES - 3'h1) begin
            d.st = ulmc_pkg::FR_DATA;
            d.halves = 3'h0;
            d.bitn = 4'h0;
            d.line = q.shift[0];
          end
        end
        ulmc_pkg::FR_DATA: begin
          if (q.halves == ulmc_pkg::BIT_HALVES - 3'h1) begin
            d.halves = 3'h0;
            d.shift = q.shift >> 1;
            d.bitn = q.bitn + 4'h1;
            d.line = q.shift[1];
            if (q.bitn == nbits - 4'h1) begin
              if (parity_on) begin
                d.st = ulmc_pkg::FR_PAR;
                d.line = q.par;
              end else begin
                d.st = ulmc_pkg::FR_STOP;
                d.line = 1'b1;
              end
            end
          end
        end
        ulmc_pkg::FR_PAR: begin
          if (q.halves == ulmc_pkg::BIT_HALVES - 3'h1) begin
            d.st = ulmc_pkg::FR_STOP;
            d.halves = 3'h0;
            d.line = 1'b1;
          end
        end
        ulmc_pkg::FR_STOP: begin
          if (q.halves == stop_halves - 3'h1) begin
            d.st = ulmc_pkg::FR_IDLE;
            d.halves = 3'h0;
          end
        end
        default: begin
          d.st = ulmc_pkg::FR_IDLE;
        end
      endcase
    end
    d.fh = (d.st != ulmc_pkg::FR_IDLE) && (d.halves == 3'h0);
    d.busy = d.pend || (d.st != ulmc_pkg::FR_IDLE);
  end

  // state register, line idles high
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      q <= '{st: ulmc_pkg::FR_IDLE, pend: 1'b0, shift: 8'h00, bitn: 4'h0, halves: 3'h0,
             par: 1'b0, line: 1'b1, fh: 1'b0, busy: 1'b0};
    end else if (ce) begin
      q <= d;
    end
  end

  assign line = q.line;
  assign first_half = q.fh;
  assign busy = q.busy;

endmodule

`default_nettype wire

// ### ulmc_top.sv
// line and modem control: registers, receiver, break, loopback, infrared, handshake
`timescale 1ns/10ps
`default_nettype none

module ulmc_top #(
  parameter int DIV_W = 16
) (
  // clock, reset, clock enable
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  // register port
  input wire logic [31:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  // receive FIFO status from outside
  input wire logic fifo_enabled,
  input wire logic rx_above_trigger,
  // serial and infrared pins
  input wire logic serial_in,
  output logic serial_out,
  input wire logic ir_in,
  output logic ir_out_n,
  // handshake pins
  input wire logic cts_n,
  output logic rts_n,
  // status
  output logic tx_busy,
  output logic rx_valid,
  output logic rx_parity_err,
  output logic rx_frame_err,
  output logic rx_break
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] lc;
    logic [6:0] mc;
    logic [15:0] div;
    logic [15:0] rdata;
    ulmc_pkg::ulmc_frame_e rst;
    logic armed;
    logic rhalf;
    logic [3:0] rbitn;
    logic [7:0] rshift;
    logic zeros;
    logic perr;
    logic [7:0] rx_hold;
    logic rx_valid;
    logic rx_perr;
    logic rx_ferr;
    logic rx_brk;
    logic serial_out;
    logic ir_out_n;
    logic rts_n;
  } ulmc_top_s;

  localparam ulmc_top_s RST_S = '{
    lc: ulmc_pkg::RST_LINE_CTL[7:0],
    mc: ulmc_pkg::RST_MODEM_CTL[6:0],
    div: ulmc_pkg::RST_DIVISOR,
    rdata: 16'h0000,
    rst: ulmc_pkg::FR_IDLE,
    armed: 1'b0,
    rhalf: 1'b0,
    rbitn: 4'h0,
    rshift: 8'h00,
    zeros: 1'b0,
    perr: 1'b0,
    rx_hold: 8'h00,
    rx_valid: 1'b0,
    rx_perr: 1'b0,
    rx_ferr: 1'b0,
    rx_brk: 1'b0,
    serial_out: 1'b1,
    ir_out_n: 1'b1,
    rts_n: 1'b1
  };

  ulmc_top_s q, d;

  logic half_tick;
  logic phase;
  logic tx_line;
  logic tx_first_half;
  logic tx_busy_w;
  logic tx_start;
  logic cts_ok;
  logic dlab;
  logic brk;
  logic loop;
  logic ir;
  logic auto_on;
  logic tx_eff;
  logic rx_line;
  logic rts_sw;
  logic [3:0] nbits;

  // ----------------------------------------------------------------
  // control decode
  // ----------------------------------------------------------------

  // current mode bits
  assign dlab = q.lc[ulmc_pkg::LC_DIV_ACCESS];
  assign brk = q.lc[ulmc_pkg::LC_BREAK];
  assign loop = q.mc[ulmc_pkg::MC_LOOP];
  assign ir = q.mc[ulmc_pkg::MC_IR];
  assign rts_sw = q.mc[ulmc_pkg::MC_RTS];
  assign auto_on = q.mc[ulmc_pkg::MC_AUTO] && fifo_enabled;
  assign nbits = ulmc_pkg::ulmc_data_bits(q.lc[ulmc_pkg::LC_LEN_LSB +: 2]);

  // transmit waits for clear-to-send only in auto mode; loopback uses own request
  assign cts_ok = !auto_on || (loop ? rts_sw : !cts_n);

  // break forces the internal transmit line to spacing
  assign tx_eff = brk ? 1'b0 : tx_line;

  // receiver source: looped transmit, infrared pulses, or serial pin
  always_comb begin
    if (loop) begin
      rx_line = tx_eff;
    end else if (ir) begin
      rx_line = ~ir_in;
    end else begin
      rx_line = serial_in;
    end
  end

  // transmit start on a data write at the shared low offset
  assign tx_start = wr && !dlab && (addr == ulmc_pkg::ADDR_DIV_LO);

  // ----------------------------------------------------------------
  // submodules
  // ----------------------------------------------------------------

  // half-bit tick from the divisor latch
  ulmc_tick #(
    .DIV_W(DIV_W)
  ) u_tick (
    .mclk(mclk),
    .rstn(rstn),
    .ce(ce),
    .divisor(q.div[DIV_W-1:0]),
    .half_tick(half_tick),
    .phase(phase)
  );

  // transmit serialiser
  ulmc_tx u_tx (
    .mclk(mclk),
    .rstn(rstn),
    .ce(ce),
    .half_tick(half_tick),
    .len(q.lc[ulmc_pkg::LC_LEN_LSB +: 2]),
    .two_stop(q.lc[ulmc_pkg::LC_STOP]),
    .parity_on(q.lc[ulmc_pkg::LC_PARITY_ON]),
    .even(q.lc[ulmc_pkg::LC_EVEN]),
    .start(tx_start),
    .data(wdata[7:0]),
    .cts_ok(cts_ok),
    .line(tx_line),
    .first_half(tx_first_half),
    .busy(tx_busy_w)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.rdata = 16'h0000;
    d.rx_valid = 1'b0;

    // register writes, reserved bits dropped
    if (wr) begin
      if (addr == ulmc_pkg::ADDR_DIV_LO) begin
        if (dlab) begin
          d.div[7:0] = wdata[7:0];
        end
      end else if (addr == ulmc_pkg::ADDR_DIV_HI) begin
        if (dlab) begin
          d.div[15:8] = wdata[7:0];
        end
      end else if (addr == ulmc_pkg::ADDR_LINE_CTL) begin
        d.lc = wdata[7:0] & ulmc_pkg::LINE_CTL_MASK[7:0];
      end else if (addr == ulmc_pkg::ADDR_MODEM_CTL) begin
        d.mc = wdata[6:0] & ulmc_pkg::MODEM_CTL_MASK[6:0];
      end
    end

    // register reads, answered in the next cycle only
    if (rd) begin
      if (addr == ulmc_pkg::ADDR_DIV_LO) begin
        d.rdata = {8'h00, dlab ? q.div[7:0] : q.rx_hold};
      end else if (addr == ulmc_pkg::ADDR_DIV_HI) begin
        d.rdata = {8'h00, dlab ? q.div[15:8] : 8'h00};
      end else if (addr == ulmc_pkg::ADDR_LINE_CTL) begin
        d.rdata = {8'h00, q.lc} & ulmc_pkg::LINE_CTL_MASK;
      end else if (addr == ulmc_pkg::ADDR_MODEM_CTL) begin
        d.rdata = {9'h000, q.mc} & ulmc_pkg::MODEM_CTL_MASK;
      end else begin
        d.rdata = 16'h0000;
      end
    end

    // receiver, sampling at the middle of each bit
    case (q.rst)
      ulmc_pkg::FR_IDLE: begin
        if (rx_line) begin
          d.armed = 1'b1;
        end else if (q.armed) begin
          d.rst = ulmc_pkg::FR_START;
        end
      end
      ulmc_pkg::FR_START: begin
        if (half_tick) begin
          if (!rx_line) begin
            d.rst = ulmc_pkg::FR_DATA;
            d.rhalf = 1'b0;
            d.rbitn = 4'h0;
            d.rshift = 8'h00;
            d.zeros = 1'b1;
            d.perr = 1'b0;
          end else begin
            d.rst = ulmc_pkg::FR_IDLE; // glitch, not a start bit
          end
        end
      end
      ulmc_pkg::FR_DATA: begin
        if (half_tick) begin
          d.rhalf = ~q.rhalf;
          if (q.rhalf) begin
            d.rshift[q.rbitn[2:0]] = rx_line;
            d.zeros = q.zeros && !rx_line;
            d.rbitn = q.rbitn + 4'h1;
            if (q.rbitn == nbits - 4'h1) begin
              d.rst = q.lc[ulmc_pkg::LC_PARITY_ON] ? ulmc_pkg::FR_PAR
                                                   : ulmc_pkg::FR_STOP;
            end
          end
        end
      end
      ulmc_pkg::FR_PAR: begin
        if (half_tick) begin
          d.rhalf = ~q.rhalf;
          if (q.rhalf) begin
            d.perr = rx_line != ulmc_pkg::ulmc_parity(q.rshift, q.lc[ulmc_pkg::LC_LEN_LSB +: 2],
                                                      q.lc[ulmc_pkg::LC_EVEN]);
            d.zeros = q.zeros && !rx_line;
            d.rst = ulmc_pkg::FR_STOP;
          end
        end
      end
      ulmc_pkg::FR_STOP: begin
        if (half_tick) begin
          d.rhalf = ~q.rhalf;
          if (q.rhalf) begin
            // only this first stop bit is looked at
            d.rst = ulmc_pkg::FR_IDLE;
            d.armed = rx_line;
            d.rx_valid = 1'b1;
            d.rx_hold = q.rshift;
            d.rx_perr = q.perr;
            d.rx_ferr = !rx_line;
            d.rx_brk = q.zeros && !rx_line;
          end
        end
      end
      default: begin
        d.rst = ulmc_pkg::FR_IDLE;
      end
    endcase

    // serial output pin
    if (loop || ir) begin
      d.serial_out = 1'b1;
    end else begin
      d.serial_out = tx_eff;
    end

    // infrared output pin, active low pulses
    if (!ir) begin
      d.ir_out_n = 1'b1;
    end else if (loop) begin
      d.ir_out_n = 1'b0;
    end else if (brk) begin
      d.ir_out_n = ~phase;
    end else begin
      d.ir_out_n = ~(~tx_line && tx_first_half);
    end

    // request-to-send pin, gated by receive fill in auto mode
    if (loop) begin
      d.rts_n = 1'b1;
    end else begin
      d.rts_n = ~(rts_sw && !(auto_on && rx_above_trigger));
    end
  end

  // ----------------------------------------------------------------
  // state register, frozen while the clock enable is low
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      q <= RST_S;
    end else if (ce) begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rdata = q.rdata;
  assign serial_out = q.serial_out;
  assign ir_out_n = q.ir_out_n;
  assign rts_n = q.rts_n;
  assign tx_busy = tx_busy_w;
  assign rx_valid = q.rx_valid;
  assign rx_parity_err = q.rx_perr;
  assign rx_frame_err = q.rx_ferr;
  assign rx_break = q.rx_brk;

endmodule

`default_nettype wire

// ### ulmc_assertions.sv
// port checker for the line and modem control block
`timescale 1ns/10ps
`default_nettype none
module ulmc_checker #(
  parameter int DIV_W = 16
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  // register port
  input wire logic [31:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] rdata,
  // pins
  input wire logic fifo_enabled,
  input wire logic rx_above_trigger,
  input wire logic serial_out,
  input wire logic ir_out_n,
  input wire logic rts_n
);
  logic [7:0] lc_q;
  logic [7:0] mc_q;
  logic [7:0] dlo_q;
  // ------
  // shadows of the control registers
  // ------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      lc_q <= 8'h00;
      mc_q <= 8'h00;
      dlo_q <= 8'h00;
    end else if (wr && ce) begin
      if (addr == ulmc_pkg::ADDR_LINE_CTL) begin
        lc_q <= wdata[7:0] & ulmc_pkg::LINE_CTL_MASK[7:0];
      end
      if (addr == ulmc_pkg::ADDR_MODEM_CTL) begin
        mc_q <= wdata[7:0] & ulmc_pkg::MODEM_CTL_MASK[7:0];
      end
      if (addr == ulmc_pkg::ADDR_DIV_LO && lc_q[7]) begin
        dlo_q <= wdata[7:0];
      end
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  // readback, divisor steering and pin relations
  a_line_readback: assert property (rd && addr == ulmc_pkg::ADDR_LINE_CTL |=>
    rdata == {8'h00, lc_q}) else $error("line control readback wrong");
  a_modem_readback: assert property (rd && addr == ulmc_pkg::ADDR_MODEM_CTL |=>
    rdata == {8'h00, mc_q}) else $error("modem control readback wrong");
  a_div_read: assert property (rd && addr == ulmc_pkg::ADDR_DIV_LO && lc_q[7] |=>
    rdata == {8'h00, dlo_q}) else $error("divisor low byte readback wrong");
  a_div_hidden: assert property (rd && addr == ulmc_pkg::ADDR_DIV_HI && !lc_q[7] |=>
    rdata == 16'h0000) else $error("divisor high byte visible without access");
  a_break_low: assert property (lc_q[6] && !mc_q[4] && !mc_q[6] |=> !serial_out)
    else $error("serial output not low during break");
  a_loop_high: assert property (mc_q[4] && !mc_q[6] |=> serial_out && rts_n)
    else $error("loopback pins not held high");
  a_loop_ir_low: assert property (mc_q[4] && mc_q[6] |=> !ir_out_n)
    else $error("infrared output not low in loopback");
  a_ir_off_idle: assert property (!mc_q[6] |=> ir_out_n)
    else $error("infrared output active while infrared off");
  a_rts_gate: assert property (!mc_q[4] |=> rts_n == !($past(mc_q[1]) &&
    !($past(mc_q[5]) && $past(fifo_enabled) && $past(rx_above_trigger))))
    else $error("request to send level wrong");

  // main scenarios reached
  c_break: cover property (lc_q[6] && !mc_q[4]);
  c_loop_break: cover property (lc_q[6] && mc_q[4]);
  c_auto_full: cover property (mc_q[5] && fifo_enabled && rx_above_trigger);
endmodule
`default_nettype wire

// ### ulmc_far_end.sv
// remote serial device: sends frames to the receive pin, decodes the transmit pin
`timescale 1ns/10ps
`default_nettype none
module ulmc_far_end #(
  parameter int D = 4
) (
  // clock
  input wire logic mclk,
  // serial pins
  input wire logic txd,
  output logic rxd,
  output logic ir_rx,
  output logic cts_n
);
  // line pulled up when idle, infrared quiet, clear to send
  initial begin
    rxd = 1'h1;
    ir_rx = 1'h0;
    cts_n = 1'h0;
  end

  // one frame: start, data lsb first, optional parity, a single stop bit
  task automatic send(input logic [7:0] d, input int n, input logic pe, input logic p,
                      input logic s);
    int k;
    @(posedge mclk);
    rxd <= 1'h0;
    repeat (2 * D) @(posedge mclk);
    for (k = 0; k < n; k++) begin
      rxd <= d[k];
      repeat (2 * D) @(posedge mclk);
    end
    if (pe) begin
      rxd <= p;
      repeat (2 * D) @(posedge mclk);
    end
    rxd <= s;
    repeat (2 * D) @(posedge mclk);
    rxd <= 1'h1;
  endtask

  // sample a frame from the transmit pin at mid bit
  task automatic recv(input int n, input logic pe, output logic [7:0] d, output logic p);
    int k;
    d = 8'h00;
    p = 1'h0;
    k = 0;
    while (txd !== 1'h0 && k < 4000) begin
      @(posedge mclk);
      k++;
    end
    repeat (D) @(posedge mclk);
    for (k = 0; k < n; k++) begin
      repeat (2 * D) @(posedge mclk);
      d[k] = txd;
    end
    if (pe) begin
      repeat (2 * D) @(posedge mclk);
      p = txd;
    end
  endtask
endmodule
`default_nettype wire

// ### tb.sv
// self-checking bench for the line and modem control block
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam int D = 4;
  localparam logic [31:0] A_LC = ulmc_pkg::ADDR_LINE_CTL;
  localparam logic [31:0] A_MC = ulmc_pkg::ADDR_MODEM_CTL;
  localparam logic [31:0] A_DL = ulmc_pkg::ADDR_DIV_LO;
  localparam logic [31:0] A_DH = ulmc_pkg::ADDR_DIV_HI;
  logic mclk = 1'h0;
  logic rstn = 1'h0;
  logic ce = 1'h1;
  logic [31:0] addr = 32'h0;
  logic [15:0] wdata = 16'h0;
  logic wr = 1'h0;
  logic rd = 1'h0;
  logic fifo_enabled = 1'h0;
  logic rx_above_trigger = 1'h0;
  logic serial_in;
  logic ir_in;
  logic cts_n;
  logic [15:0] rdata;
  logic serial_out;
  logic ir_out_n;
  logic rts_n;
  logic tx_busy;
  logic rx_valid;
  logic rx_parity_err;
  logic rx_frame_err;
  logic rx_break;
  int failures = 0;
  int checked = 0;
  int i;
  int k;
  int n;
  int cnt;
  int cnt2;
  logic pe;
  logic p;
  logic prev;
  logic brk_seen = 1'h0;
  logic [7:0] d;
  logic [7:0] x;
  logic [7:0] fmt [4];
  logic [1:0] rxq [$];

  ulmc_top #(.DIV_W(16)) u_ulmc_top (.mclk(mclk), .rstn(rstn), .ce(ce), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .fifo_enabled(fifo_enabled),
    .rx_above_trigger(rx_above_trigger), .serial_in(serial_in), .serial_out(serial_out),
    .ir_in(ir_in), .ir_out_n(ir_out_n), .cts_n(cts_n), .rts_n(rts_n), .tx_busy(tx_busy),
    .rx_valid(rx_valid), .rx_parity_err(rx_parity_err), .rx_frame_err(rx_frame_err),
    .rx_break(rx_break));
  ulmc_far_end #(.D(D)) u_ulmc_far_end (.mclk(mclk), .txd(serial_out), .rxd(serial_in),
    .ir_rx(ir_in), .cts_n(cts_n));

  // clock and received-character log
  always #4 mclk = ~mclk;
  always @(posedge mclk) begin
    if (rx_valid === 1'h1) begin
      rxq.push_back({rx_parity_err, rx_frame_err});
      if (rx_break === 1'h1) brk_seen = 1'h1;
    end
  end

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [31:0] a, input logic [15:0] v);
    addr <= a;
    wdata <= v;
    wr <= 1'h1;
    @(posedge mclk);
    wr <= 1'h0;
    @(posedge mclk); // gap edge, strobe never reassigned in one step
  endtask

  task automatic rd_reg(input logic [31:0] a, input logic [15:0] e, input string nm);
    addr <= a;
    rd <= 1'h1;
    @(posedge mclk);
    rd <= 1'h0;
    #1;
    chk(nm, rdata, e);
    @(posedge mclk);
  endtask

  task automatic wait_idle();
    k = 0;
    while (tx_busy === 1'h1 && k < 400) begin
      @(posedge mclk);
      k++;
    end
  endtask

  task automatic stop_test();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // watchdog
  initial begin
    #500000;
    failures++;
    stop_test();
  end

  initial begin
    fmt = '{8'h1C, 8'h09, 8'h06, 8'h0F};
    repeat (6) @(posedge mclk);
    rstn <= 1'h1;
    @(posedge mclk);
    // reset values, reserved bits, unmapped place, divisor steering
    rd_reg(A_LC, 16'h0000, "line_rst");
    rd_reg(A_MC, 16'h0000, "modem_rst");
    wr_reg(A_LC, 16'hFFFF);
    rd_reg(A_LC, 16'h00DF, "line_rsvd");
    wr_reg(A_MC, 16'hFFFF);
    rd_reg(A_MC, 16'h0072, "modem_rsvd");
    wr_reg(A_MC, 16'h0000);
    rd_reg(32'h5000_1020, 16'h0000, "unmapped");
    wr_reg(A_LC, 16'h0080);
    wr_reg(A_DL, 16'(D));
    wr_reg(A_DH, 16'h0000);
    rd_reg(A_DL, 16'(D), "div_lo");
    wr_reg(A_LC, 16'h0003);
    rd_reg(A_DL, 16'h0000, "rx_char");
    rd_reg(A_DH, 16'h0000, "div_hidden");
    // transmit in every length, parity sense and stop count
    for (i = 0; i < 4; i++) begin
      wr_reg(A_LC, {8'h00, fmt[i]});
      n = 5 + fmt[i][1:0];
      pe = fmt[i][3];
      cnt = !fmt[i][2] ? 2 : (n == 5 ? 3 : 4);
      x = (8'hB6 ^ 8'(i)) & (8'hFF >> (8 - n));
      wr_reg(A_DL, {8'h00, 8'hB6 ^ 8'(i)});
      u_ulmc_far_end.recv(n, pe, d, p);
      wait_idle();
      chk("tx_data", {8'h00, d}, {8'h00, x});
      chk("tx_parity", 16'(p), 16'(pe & (^x ^ ~fmt[i][4])));
      chk("tx_stop", 16'((k + 2) / D), 16'(cnt + 1));
    end
    // receive two frames back to back, then one with a low stop bit
    wr_reg(A_LC, 16'h001F);
    rxq.delete();
    u_ulmc_far_end.send(8'h3C, 8, 1'h1, 1'h0, 1'h1);
    u_ulmc_far_end.send(8'h81, 8, 1'h1, 1'h1, 1'h1);
    u_ulmc_far_end.send(8'h55, 8, 1'h1, 1'h0, 1'h0);
    repeat (4 * D) @(posedge mclk);
    rd_reg(A_DL, 16'h0055, "rx_data");
    chk("rx_count", 16'(rxq.size()), 16'h0003);
    chk("rx_good", 16'(rxq[0]), 16'h0000);
    chk("rx_par", 16'(rxq[1]), 16'h0002);
    chk("rx_stop", 16'(rxq[2]), 16'h0001);
    // forced break on the plain line
    wr_reg(A_LC, 16'h0043);
    repeat (40) @(posedge mclk);
    chk("brk_low", 16'(serial_out), 16'h0000);
    wr_reg(A_LC, 16'h0003);
    repeat (3) @(posedge mclk);
    chk("brk_end", 16'(serial_out), 16'h0001);
    // loopback data, then a looped break
    wr_reg(A_MC, 16'h0010);
    wr_reg(A_DL, 16'h00C3);
    repeat (4) @(posedge mclk);
    chk("loop_pins", 16'({serial_out, rts_n}), 16'h0003);
    wait_idle();
    repeat (4 * D) @(posedge mclk);
    rd_reg(A_DL, 16'h00C3, "loop_data");
    brk_seen = 1'h0;
    wr_reg(A_LC, 16'h0043);
    k = 0;
    while (brk_seen !== 1'h1 && k < 400) begin
      @(posedge mclk);
      k++;
    end
    chk("loop_brk", 16'(brk_seen), 16'h0001);
    wr_reg(A_MC, 16'h0050);
    repeat (3) @(posedge mclk);
    chk("loop_ir", 16'(ir_out_n), 16'h0000);
    // infrared: pulses during break, then one character
    wr_reg(A_MC, 16'h0040);
    cnt = 0;
    prev = ir_out_n;
    repeat (40) begin
      @(posedge mclk);
      if (ir_out_n !== prev) cnt++;
      prev = ir_out_n;
    end
    chk("ir_brk", 16'(cnt > 4), 16'h0001);
    wr_reg(A_LC, 16'h0003);
    wr_reg(A_DL, 16'h0000);
    cnt = 0;
    cnt2 = 0;
    repeat (120) begin
      @(posedge mclk);
      if (ir_out_n === 1'h0) cnt++;
      if (serial_out !== 1'h1) cnt2++;
    end
    chk("ir_pulses", 16'({cnt > 0, cnt2 == 0}), 16'h0003);
    wr_reg(A_MC, 16'h0000);
    repeat (3) @(posedge mclk);
    chk("ir_off", 16'(ir_out_n), 16'h0001);
    // automatic request and clear to send
    wr_reg(A_MC, 16'h0022);
    fifo_enabled <= 1'h1;
    rx_above_trigger <= 1'h1;
    repeat (3) @(posedge mclk);
    chk("rts_full", 16'(rts_n), 16'h0001);
    rx_above_trigger <= 1'h0;
    repeat (3) @(posedge mclk);
    chk("rts_room", 16'(rts_n), 16'h0000);
    fifo_enabled <= 1'h0;
    rx_above_trigger <= 1'h1;
    repeat (3) @(posedge mclk);
    chk("rts_nofifo", 16'(rts_n), 16'h0000);
    fifo_enabled <= 1'h1;
    u_ulmc_far_end.cts_n <= 1'h1;
    wr_reg(A_DL, 16'h005A);
    repeat (40) @(posedge mclk);
    chk("cts_hold", 16'({tx_busy, serial_out}), 16'h0003);
    u_ulmc_far_end.cts_n <= 1'h0;
    repeat (2) @(posedge mclk);
    wait_idle();
    chk("cts_go", 16'(tx_busy), 16'h0000);
    // clock enable low: a write must leave the registers untouched
    ce <= 1'h0;
    wr_reg(A_LC, 16'h001B);
    ce <= 1'h1;
    rd_reg(A_LC, 16'h0003, "ce_freeze");
    stop_test();
  end
endmodule

bind ulmc_top ulmc_checker #(.DIV_W(DIV_W)) u_ulmc_checker (.mclk(mclk), .rstn(rstn),
  .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .fifo_enabled(fifo_enabled), .rx_above_trigger(rx_above_trigger),
  .serial_out(serial_out), .ir_out_n(ir_out_n), .rts_n(rts_n));
`default_nettype wire
